// file: inc/sma_burst_if.sv
// link between command decode and the column sequencer
interface sma_burst_if #(parameter int COL_W = 9);
    logic             start;
    logic             stop;
    logic [COL_W-1:0] col_start;
    logic [2:0]       len_code;
    logic             interleave;
    logic [COL_W-1:0] col;
    logic             active;
    logic             last;
    modport ctrl (output start, stop, col_start, len_code, interleave, input col, active, last);
    modport eng  (input start, stop, col_start, len_code, interleave, output col, active, last);
endinterface

// file: inc/sma_defines.svh
// field positions, reset values and codes for the sdram mode front end
`ifndef SMA_DEFINES_SVH
`define SMA_DEFINES_SVH
`define SMA_BL_LSB        0
`define SMA_ORDER_BIT     3
`define SMA_CL_LSB        4
`define SMA_OPMODE_LSB    7
`define SMA_WSINGLE_BIT   9
`define SMA_PARTIAL_ARRAY_REFRESH_SELECT_LSB      0
`define SMA_TEMPERATURE_SCALED_REFRESH_CONTROL_LSB      3
`define SMA_DS_LSB        5
`define SMA_PREC_BIT      10
`define SMA_MODE_RESET    13'h0020
`define SMA_PARTIAL_ARRAY_REFRESH_SELECT_RESET    3'h0
`define SMA_TEMPERATURE_SCALED_REFRESH_CONTROL_RESET    2'h3
`define SMA_DS_RESET      2'h0
`define SMA_BL_1          3'h0
`define SMA_BL_2          3'h1
`define SMA_BL_4          3'h2
`define SMA_BL_8          3'h3
`define SMA_BL_PAGE       3'h7
`define SMA_CL_2          3'h2
`define SMA_CL_3          3'h3
`define SMA_BA_MODE       2'h0
`define SMA_BA_EXT        2'h2
`endif

// file: inc/sma_pkg.sv
// types shared by the sdram mode front end
package sma_pkg;
    typedef enum logic [2:0] {
        SMA_CMD_LOAD  = 3'b000,
        SMA_CMD_REF   = 3'b001,
        SMA_CMD_PRE   = 3'b010,
        SMA_CMD_ACT   = 3'b011,
        SMA_CMD_WR    = 3'b100,
        SMA_CMD_RD    = 3'b101,
        SMA_CMD_STOP  = 3'b110,
        SMA_CMD_NOP   = 3'b111
    } sma_cmd_t;
    typedef enum logic {
        SMA_BURST_IDLE = 1'b0,
        SMA_BURST_RUN  = 1'b1
    } sma_burst_state_t;
endpackage

// file: rtl/sma_burst.sv
// column sequencer: walks one burst inside its aligned block
`include "sma_defines.svh"
module sma_burst #(
    parameter int COL_W = 9
) (
    input  wire logic  sys_clk_i,
    input  wire logic  rst_b_i,
    sma_burst_if.eng   bus
);
    import sma_pkg::*;

    sma_burst_state_t state;
    logic [COL_W-1:0] base;
    logic [COL_W-1:0] cnt;
    logic [COL_W-1:0] mask;
    logic             full;

    function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
        unique case (code)
            `SMA_BL_2:    len_mask = COL_W'(1);
            `SMA_BL_4:    len_mask = COL_W'(3);
            `SMA_BL_8:    len_mask = COL_W'(7);
            `SMA_BL_PAGE: len_mask = '1;
            default:      len_mask = '0;
        endcase
    endfunction

    // interleave on a full page is reserved; it falls back to sequential
    function automatic logic [COL_W-1:0] walk(input logic [COL_W-1:0] b, input logic [COL_W-1:0] c,
                                              input logic [COL_W-1:0] m, input logic il);
        logic [COL_W-1:0] low;
        low = il ? (b ^ c) : COL_W'(b + c);
        walk = (b & ~m) | (low & m);
    endfunction

    logic             ilv;
    logic [COL_W-1:0] next_cnt;
    assign next_cnt   = COL_W'(cnt + 1'b1);
    assign bus.active = (state == SMA_BURST_RUN);
    assign bus.last   = bus.active && !full && (cnt == mask);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state <= SMA_BURST_IDLE;
            base  <= '0;
            cnt   <= '0;
            mask  <= '0;
            full  <= 1'b0;
            ilv   <= 1'b0;
            bus.col <= '0;
        end else if (bus.start) begin
            state   <= SMA_BURST_RUN;
            base    <= bus.col_start;
            cnt     <= '0;
            mask    <= len_mask(bus.len_code);
            full    <= (bus.len_code == `SMA_BL_PAGE);
            ilv     <= bus.interleave && (bus.len_code != `SMA_BL_PAGE);
            bus.col <= bus.col_start;
        end else if (bus.active) begin
            if (bus.stop || bus.last) begin
                state <= SMA_BURST_IDLE;
            end else begin
                cnt     <= next_cnt;
                bus.col <= walk(base, next_cnt, mask, ilv);
            end
        end
    end
endmodule

// file: rtl/sma_front.sv
// sdram mode registers, bank tracking and burst front end
`include "sma_defines.svh"
module sma_front #(
    parameter int ROW_W = 13,
    parameter int COL_W = 9,
    parameter int REF_W = 16
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       cs_b_i,
    input  wire logic                       ras_b_i,
    input  wire logic                       cas_b_i,
    input  wire logic                       we_b_i,
    input  wire logic [1:0]                 bank_select_i,
    input  wire logic [12:0]                addr_i,
    output logic [3:0]                      bank_open_o,
    output logic [3:0][ROW_W-1:0]           open_row_o,
    output logic [3:0]                      precharge_start_o,
    output logic [COL_W-1:0]                col_addr_o,
    output logic [1:0]                      col_bank_o,
    output logic                            wr_beat_o,
    output logic                            rd_drive_o,
    output logic [COL_W-1:0]                rd_col_o,
    output logic [12:0]                     operating_mode_register_o,
    output logic [2:0]                      partial_array_refresh_select_o,
    output logic [1:0]                      temperature_scaled_refresh_control_o,
    output logic [1:0]                      output_drive_level_o,
    output logic                            mode_reserved_o,
    output logic                            refresh_pulse_o,
    output logic [REF_W-1:0]                refresh_count_o
);
    import sma_pkg::*;

    sma_burst_if #(.COL_W(COL_W)) bif ();

    sma_burst #(.COL_W(COL_W)) u_burst (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .bus       (bif.eng)
    );

    function automatic sma_cmd_t decode(input logic cs_b, input logic ras_b, input logic cas_b, input logic we_b);
        decode = cs_b ? SMA_CMD_NOP : sma_cmd_t'({ras_b, cas_b, we_b});
    endfunction

    sma_cmd_t    cmd;
    logic        col_cmd;
    logic        is_rd;
    logic [2:0]  bl_code;
    logic [2:0]  cl_code;
    logic        wsingle;
    logic        ap_pend;
    logic [1:0]  ap_bank;
    logic        burst_done;
    logic [1:0]  rd_pipe;
    logic [1:0][COL_W-1:0] rd_col_pipe;
    logic [6:0]  ext_reg;

    assign cmd     = decode(cs_b_i, ras_b_i, cas_b_i, we_b_i);
    assign col_cmd = (cmd == SMA_CMD_RD) || (cmd == SMA_CMD_WR);
    assign bl_code = operating_mode_register_o[`SMA_BL_LSB +: 3];
    assign cl_code = operating_mode_register_o[`SMA_CL_LSB +: 3];
    assign wsingle = operating_mode_register_o[`SMA_WSINGLE_BIT];

    // flag codes the controller must not use
    assign mode_reserved_o = (bl_code inside {3'h4, 3'h5, 3'h6})
                           || (bl_code == `SMA_BL_PAGE && operating_mode_register_o[`SMA_ORDER_BIT])
                           || !(cl_code inside {`SMA_CL_2, `SMA_CL_3})
                           || (operating_mode_register_o[`SMA_OPMODE_LSB +: 2] != 2'h0);

    // burst launch; a fresh column command restarts the sequencer at once
    assign bif.start      = col_cmd;
    assign bif.stop       = (cmd == SMA_CMD_STOP);
    assign bif.col_start  = addr_i[COL_W-1:0];
    assign bif.len_code   = ((cmd == SMA_CMD_WR) && wsingle) ? `SMA_BL_1 : bl_code;
    assign bif.interleave = operating_mode_register_o[`SMA_ORDER_BIT];

    // a burst ends at its last beat, on a stop, or when cut by a new column command
    assign burst_done = bif.last || (bif.active && (bif.stop || col_cmd));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            operating_mode_register_o <= `SMA_MODE_RESET;
            ext_reg <= {`SMA_DS_RESET, `SMA_TEMPERATURE_SCALED_REFRESH_CONTROL_RESET, `SMA_PARTIAL_ARRAY_REFRESH_SELECT_RESET};
        end else if (cmd == SMA_CMD_LOAD) begin
            if (bank_select_i == `SMA_BA_MODE) begin
                operating_mode_register_o <= addr_i;
            end else if (bank_select_i == `SMA_BA_EXT) begin
                ext_reg <= addr_i[6:0];
            end
        end
    end

    assign partial_array_refresh_select_o       = ext_reg[`SMA_PARTIAL_ARRAY_REFRESH_SELECT_LSB +: 3];
    assign temperature_scaled_refresh_control_o = ext_reg[`SMA_TEMPERATURE_SCALED_REFRESH_CONTROL_LSB +: 2];
    assign output_drive_level_o                 = ext_reg[`SMA_DS_LSB +: 2];

    // each bank keeps its own open flag so one can close while another bursts
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            bank_open_o       <= '0;
            open_row_o        <= '0;
            precharge_start_o <= '0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                precharge_start_o[b] <= 1'b0;
                if (cmd == SMA_CMD_ACT && bank_select_i == 2'(b)) begin
                    bank_open_o[b] <= 1'b1;
                    open_row_o[b]  <= addr_i[ROW_W-1:0];
                end else if (cmd == SMA_CMD_PRE && (addr_i[`SMA_PREC_BIT] || bank_select_i == 2'(b))) begin
                    bank_open_o[b]       <= 1'b0;
                    precharge_start_o[b] <= bank_open_o[b];
                end else if (ap_pend && burst_done && ap_bank == 2'(b)) begin
                    bank_open_o[b]       <= 1'b0;
                    precharge_start_o[b] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ap_pend    <= 1'b0;
            ap_bank    <= '0;
            col_bank_o <= '0;
            is_rd      <= 1'b0;
        end else if (col_cmd) begin
            ap_pend    <= addr_i[`SMA_PREC_BIT];
            ap_bank    <= bank_select_i;
            col_bank_o <= bank_select_i;
            is_rd      <= (cmd == SMA_CMD_RD);
        end else if (burst_done) begin
            ap_pend <= 1'b0;
        end
    end

    assign col_addr_o = bif.col;
    assign wr_beat_o  = bif.active && !is_rd;

    // a two-stage pipe covers both latencies; latency three taps the later stage
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_pipe     <= '0;
            rd_col_pipe <= '0;
        end else begin
            rd_pipe     <= {rd_pipe[0], bif.active && is_rd};
            rd_col_pipe <= {rd_col_pipe[0], bif.col};
        end
    end

    assign rd_drive_o = (cl_code == `SMA_CL_3) ? rd_pipe[1] : rd_pipe[0];
    assign rd_col_o   = (cl_code == `SMA_CL_3) ? rd_col_pipe[1] : rd_col_pipe[0];

    // refreshes are only counted; the interval is the controller's duty
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            refresh_pulse_o <= 1'b0;
            refresh_count_o <= '0;
        end else begin
            refresh_pulse_o <= (cmd == SMA_CMD_REF);
            if (cmd == SMA_CMD_REF) begin
                refresh_count_o <= REF_W'(refresh_count_o + 1'b1);
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_bl4_read;
        (cmd == SMA_CMD_RD && bl_code == `SMA_BL_4) ##1 (!col_cmd && cmd != SMA_CMD_STOP)[*3];
    endsequence

    a_cl2_read_drive: assert property ((cmd == SMA_CMD_RD && cl_code == `SMA_CL_2) |-> ##2 rd_drive_o)
        else $error("read data not driven two cycles after read at latency two");
    a_cl3_read_drive: assert property ((cmd == SMA_CMD_RD && cl_code == `SMA_CL_3) |-> ##3 rd_drive_o)
        else $error("read data not driven three cycles after read at latency three");
    a_mode_load_store: assert property ((cmd == SMA_CMD_LOAD && bank_select_i == `SMA_BA_MODE)
                                        |=> operating_mode_register_o == $past(addr_i))
        else $error("mode register did not take the address bus");
    a_ext_load_store: assert property ((cmd == SMA_CMD_LOAD && bank_select_i == `SMA_BA_EXT)
                                       |=> (ext_reg == $past(addr_i[6:0])) && $stable(operating_mode_register_o))
        else $error("low-power register load went astray");
    a_activate_opens: assert property ((cmd == SMA_CMD_ACT)
                                       |=> bank_open_o[$past(bank_select_i)]
                                           && open_row_o[$past(bank_select_i)] == $past(addr_i[ROW_W-1:0]))
        else $error("activate did not open the addressed row");
    a_bl4_burst_len: assert property (s_bl4_read |=> bif.last)
        else $error("four-beat burst did not end on its fourth beat");
    a_auto_prech_close: assert property ((ap_pend && burst_done && cmd != SMA_CMD_ACT)
                                         |=> !bank_open_o[$past(ap_bank)] && precharge_start_o[$past(ap_bank)])
        else $error("auto precharge did not close the bank after the burst");
    a_write_single_loc: assert property ((cmd == SMA_CMD_WR && wsingle) |=> bif.last)
        else $error("write was not a single location with write bit set");
    // an auto precharge or a burst ending in the same cycle is not this command's doing
    a_bank_prech_indep: assert property ((cmd == SMA_CMD_PRE && !addr_i[`SMA_PREC_BIT] && !(ap_pend && burst_done))
                                         |=> ((bank_open_o ^ $past(bank_open_o))
                                              & ~(4'h1 << $past(bank_select_i))) == 4'h0
                                             && (bif.active || !$past(bif.active && !bif.last)))
        else $error("single-bank precharge disturbed other banks or the burst");
endmodule

// file: verif/sma_ctl_model.sv
// memory controller model that drives the command pins
module sma_ctl_model (
    input  wire logic        sys_clk_i,
    output logic             cs_b_o,
    output logic [2:0]       cmd_o,
    output logic [1:0]       bank_o,
    output logic [12:0]      addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import sma_pkg::*;
    logic [3:0] opened;
    initial begin
        cs_b_o = 1'b1;
        cmd_o = SMA_CMD_NOP;
        bank_o = 2'h0;
        addr_o = 13'h0000;
        opened = 4'h0;
    end
    // released lines show the inverse, so a stale bank or address never passes for a fresh one
    task automatic drive(input sma_cmd_t c, input logic [1:0] b, input logic [12:0] a);
        @(negedge sys_clk_i);
        cs_b_o = 1'b0;
        cmd_o = c;
        bank_o = b;
        addr_o = a;
        @(negedge sys_clk_i);
        cs_b_o = 1'b1;
        cmd_o = SMA_CMD_NOP;
        bank_o = ~b;
        addr_o = ~a;
    endtask
    task automatic issue(input sma_cmd_t c, input logic [1:0] b, input logic [12:0] a);
        if (c == SMA_CMD_LOAD && opened != 4'h0) begin
            drive(SMA_CMD_PRE, 2'h0, 13'h0400);
            opened = 4'h0;
        end
        if ((c == SMA_CMD_RD || c == SMA_CMD_WR) && !opened[b]) begin
            drive(SMA_CMD_ACT, b, 13'h0000);
            opened[b] = 1'b1;
        end
        drive(c, b, a);
        case (c)
            SMA_CMD_ACT: opened[b] = 1'b1;
            SMA_CMD_PRE: opened = a[10] ? 4'h0 : opened & ~(4'h1 << b);
            SMA_CMD_RD, SMA_CMD_WR: opened[b] = opened[b] & !a[10];
            default: ;
        endcase
    endtask
endmodule

// file: verif/sma_front_tb.sv
// self-checking bench for the sdram mode front end
`include "sma_defines.svh"
module sma_front_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sma_pkg::*;
    logic             sys_clk_i;
    logic             rst_b_i;
    logic             cs_b, wr_beat, rd_drive, mres, ref_p;
    logic [2:0]       cmd, partial_array_refresh_select, bl;
    logic [1:0]       ba, col_bank, temperature_scaled_refresh_control, ds, b;
    logic [12:0]      addr, mode, v, row;
    logic [3:0]       bank_open, pre_start;
    logic [3:0][12:0] open_row;
    logic [8:0]       col, rd_col, s;
    logic [15:0]      ref_cnt;
    logic [12:0]      corner [3];
    int               seed, failures, cmp_count, m, len, wl;
    sma_cmd_t         c;
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    sma_ctl_model ctl (.sys_clk_i(sys_clk_i), .cs_b_o(cs_b), .cmd_o(cmd), .bank_o(ba), .addr_o(addr));
    sma_front #(.ROW_W(13), .COL_W(9), .REF_W(16)) dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
        .ras_b_i(cmd[2]), .cas_b_i(cmd[1]), .we_b_i(cmd[0]),
        .bank_select_i(ba), .addr_i(addr), .bank_open_o(bank_open),
        .open_row_o(open_row), .precharge_start_o(pre_start), .col_addr_o(col),
        .col_bank_o(col_bank), .wr_beat_o(wr_beat), .rd_drive_o(rd_drive), .rd_col_o(rd_col),
        .operating_mode_register_o(mode), .partial_array_refresh_select_o(partial_array_refresh_select),
        .temperature_scaled_refresh_control_o(temperature_scaled_refresh_control), .output_drive_level_o(ds),
        .mode_reserved_o(mres), .refresh_pulse_o(ref_p), .refresh_count_o(ref_cnt));
    function automatic logic [8:0] exp_col(input logic [8:0] st, input int k, input logic [2:0] l, input logic il);
        logic [8:0] mk;
        mk = (9'h001 << l) - 9'h001;
        return (st & ~mk) | ((il ? st ^ 9'(k) : st + 9'(k)) & mk);
    endfunction
    function automatic logic exp_res(input logic [12:0] x);
        return x[2:0] inside {3'h4, 3'h5, 3'h6} || x[3:0] == 4'hF || !(x[6:4] inside {3'h2, 3'h3}) || x[8:7] != 2'h0;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("ERROR t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one spare cycle lets the register settle whatever edge it updates on
    task automatic load(input logic [1:0] bb, input logic [12:0] x);
        ctl.issue(SMA_CMD_LOAD, bb, x);
        @(negedge sys_clk_i);
    endtask
    // the whole run needs well under 1000 cycles; 20000 leaves ample margin
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
    initial begin
        rst_b_i = 1'b0;
        seed = 32'hE2A449C8;
        failures = 0;
        cmp_count = 0;
        corner = '{13'h0027, 13'h002F, 13'h00B3};
        repeat (16) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        check(mode, `SMA_MODE_RESET);
        check({partial_array_refresh_select, temperature_scaled_refresh_control, ds}, {3'h0, 2'h3, 2'h0});
        check({bank_open, ref_cnt}, 20'h00000);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            v = (i < 3) ? corner[i] : 13'($random(seed));
            load(`SMA_BA_MODE, v);
            check(mode, v);
            check(mres, exp_res(v));
            load({i[0], 1'b1}, ~v);
            check(mode, v);
            load(`SMA_BA_EXT, v);
            check({partial_array_refresh_select, temperature_scaled_refresh_control, ds, mode}, {v[2:0], v[4:3], v[6:5], v});
        end
        $display("register test done");
        for (int i = 0; i < 16; i++) begin
            v = 13'($random(seed));
            bl = {1'b0, i[1:0]};
            m = v[0] ? 3 : 2;
            len = 1 << bl;
            c = v[6] ? SMA_CMD_RD : SMA_CMD_WR;
            wl = (c == SMA_CMD_WR && v[1]) ? 1 : len;
            row = 13'($random(seed));
            s = 9'($random(seed));
            b = v[4:3];
            load(`SMA_BA_MODE, {3'h0, v[1], 2'h0, 3'(m), v[2], bl});
            ctl.issue(SMA_CMD_ACT, b, row);
            ctl.issue(SMA_CMD_ACT, b ^ 2'h1, ~row);
            ctl.issue(SMA_CMD_PRE, b ^ 2'h1, 13'h0000);
            check({pre_start, bank_open, open_row[b]}, {4'h1 << (b ^ 2'h1), 4'h1 << b, row});
            ctl.issue(c, b, {2'h0, v[5], 1'b0, s});
            for (int j = 0; j <= len + m; j++) begin
                if (j < wl) check({col_bank, col}, {b, exp_col(s, j, bl, v[2])});
                check(wr_beat, c == SMA_CMD_WR && j < wl);
                check(rd_drive, c == SMA_CMD_RD && j >= m - 1 && j < len + m - 1);
                if (c == SMA_CMD_RD && j >= m - 1 && j < len + m - 1) check(rd_col, exp_col(s, j - m + 1, bl, v[2]));
                if (j == (c == SMA_CMD_WR ? wl : len)) check({pre_start[b], bank_open[b]}, {v[5], !v[5]});
                @(negedge sys_clk_i);
            end
        end
        $display("burst test done");
        // page burst wraps the page, keeps running while another bank closes, ends on stop
        load(`SMA_BA_MODE, 13'h0027);
        ctl.issue(SMA_CMD_ACT, 2'h0, 13'h0155);
        ctl.issue(SMA_CMD_WR, 2'h1, 13'h01FE);
        for (int j = 0; j < 4; j++) begin
            check({col_bank, col, wr_beat}, {2'h1, 9'(9'h1FE + j), 1'b1});
            @(negedge sys_clk_i);
        end
        ctl.issue(SMA_CMD_PRE, 2'h0, 13'h0000);
        check({pre_start, bank_open, wr_beat}, {4'h1, 4'h2, 1'b1});
        ctl.issue(SMA_CMD_STOP, 2'h1, 13'h0000);
        check({wr_beat, bank_open}, {1'b0, 4'h2});
        $display("page test done");
        for (int i = 1; i <= 3; i++) begin
            ctl.issue(SMA_CMD_REF, 2'h0, 13'h0000);
            check({ref_p, ref_cnt}, {1'b1, 16'(i)});
        end
        $display("refresh test done");
        wrap_up();
    end
endmodule
